// ### cfg_integrity_pkg.sv
// package: register map, field positions, reset values and timing for the register bank
//
// Notes on behaviour
// - die temperature is an 8-bit read-only code at 0x02, one degree per step.
// - above fixed temperature limit set overtemp flag, kill laser, assert error output.
// - overtemp flag at 0x00 bit 3 stays latched until host reads that register.
// - sim bit at 0x16 bit 4 forces overtemp flag; error holds until cleared.
// - interface select pin chooses SPI or I2C host protocol.
// - config-mode writes leave applied settings; return to operation applies all at once.
// - each configuration write also stores its inverse in the validation page.
// - any config/validation bit mismatch raises memory error and turns laser off.
// - mode field 0x1C: 01 operation, 10 configuration, 00/11 memory error; resets 01.
// - configuration mode allows write and readback of 0x10-0x1F; integrity check off.
// - time spent in configuration mode; laser off once the timeout passes.
// - operation mode applies config, checks integrity, rejects config writes except mode.
// - 64 addresses: read-only 0x00-0x0F, config 0x10-0x1F, validation 0x30-0x3F.
// - status registers 0x00 and 0x01 latch events and clear on read.
// - measurement registers readable at any time while hardware updates them.
// - 10-bit result at 0x03/0x04 stays coherent across one burst read.
// - validation page is plain storage; inverse copy only on configuration writes.
// - active-low error output asserted whenever any unmasked status bit is set.
// - configuration-mode timeout latches event flag at 0x00 bit 7.
package cfg_integrity_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [5:0] ADDR_STATUS0   = 6'h00;
  localparam logic [5:0] ADDR_STATUS1   = 6'h01;
  localparam logic [5:0] ADDR_TEMP      = 6'h02;
  localparam logic [5:0] ADDR_RESULT_HI = 6'h03;
  localparam logic [5:0] ADDR_RESULT_LO = 6'h04;
  localparam logic [5:0] ADDR_REVISION  = 6'h0f;
  localparam logic [5:0] ADDR_SIM_CTRL  = 6'h16;
  localparam logic [5:0] ADDR_MODE      = 6'h1c;

  localparam logic [1:0] PAGE_RO  = 2'b00;
  localparam logic [1:0] PAGE_CFG = 2'b01;
  localparam logic [1:0] PAGE_VAL = 2'b11;

  localparam int unsigned BIT_INIT_RAM = 0;
  localparam int unsigned BIT_MEM_ERR  = 2;
  localparam int unsigned BIT_OVERTEMP = 3;
  localparam int unsigned BIT_TIMEOUT  = 7;
  localparam int unsigned BIT_SIM_OVT  = 4;

  localparam logic [1:0] MODE_OPERATE   = 2'b01;
  localparam logic [1:0] MODE_CONFIGURE = 2'b10;

  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] MODE_REG_RESET = 8'h05;
  localparam logic [7:0] INIT_STATUS0   = 8'h01;

  localparam int unsigned CLOCK_HZ     = 20_000_000;
  localparam int unsigned CFG_TIMEOUT_MS = 40;
  localparam int unsigned CFG_TIMEOUT_CYC = CLOCK_HZ / 1000 * CFG_TIMEOUT_MS;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       burst;
    logic [5:0] addr;
    logic [7:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } host_rsp_type;

  typedef enum logic [1:0] {
    PROTO_SPI = 2'b00,
    PROTO_I2C = 2'b01
  } proto_type;

endpackage

// ### config_integrity_register_bank.sv
// register bank: pages, shadow latch, inverse validation, overtemp and timeout logic
module config_integrity_register_bank
  import cfg_integrity_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = CFG_TIMEOUT_CYC,  // config-mode limit in cycles
  parameter logic [7:0]  REVISION_CODE  = 8'h5a,            // arbitrary value
  parameter logic [7:0]  OVT_LIMIT      = 8'hc8             // fixed overtemp code
) (
  input  wire logic         i_clock,                // 20 MHz clock
  input  wire logic         i_sys_rst,              // sync reset, active high
  input  wire host_req_type i_req,                  // decoded host access
  output host_rsp_type      o_rsp,                  // read data
  input  wire logic         i_interface_select_pin, // pin: 0 spi, 1 i2c
  output proto_type         o_proto,                // chosen host protocol
  input  wire logic [7:0]   i_temp_code,            // die temperature from monitor
  input  wire logic [9:0]   i_adc_result,           // conversion result
  input  wire logic [7:0]   i_status0_events,       // other status0 event pulses
  input  wire logic [7:0]   i_status1_events,       // status1 event pulses
  input  wire logic [7:0]   i_status_mask,          // 1 masks a status bit
  output logic [127:0]      o_applied_cfg,          // latched config, 0x10 lowest
  output logic              o_laser_enable,         // laser channel enable
  output logic              o_error_out_n           // error output, active low
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [15:0][7:0] val;
    logic [15:0][7:0] applied;
    logic [7:0]       status0;
    logic [7:0]       status1;
    logic [7:0]       temp;
    logic [9:0]       adc_hold;
    logic             in_burst;
    logic [31:0]      cfg_time;
    logic             timed_out;
    logic [2:0]       sel_sync;
    proto_type        proto;
    host_rsp_type     rsp;
  } state_type;

  state_type s_r;
  state_type s_nxt;

  logic       cfg_mode;
  logic       mode_bad;
  logic       mismatch;
  logic       ovt_now;
  logic [5:0] a;
  logic [3:0] idx;
  logic [1:0] mode_now;

  logic [15:0] entry_bad;

  assign a        = i_req.addr;
  assign idx      = a[3:0];
  assign mode_now = s_r.cfg[4'hc][1:0];
  assign cfg_mode = (mode_now == MODE_CONFIGURE);
  assign mode_bad = (mode_now != MODE_CONFIGURE) && (mode_now != MODE_OPERATE);

  // one comparator per configuration entry against its inverted copy
  for (genvar g = 0; g < 16; g++) begin : g_cmp
    assign entry_bad[g] = (s_r.cfg[g] != ~s_r.val[g]);
  end

  // integrity compare, suspended while configuring
  assign mismatch = (|entry_bad) && !cfg_mode;

  // fixed limit or simulated event; sim holds the error until written to zero
  assign ovt_now = (s_r.temp > OVT_LIMIT) || s_r.applied[4'h6][BIT_SIM_OVT];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp.rvalid = 1'b0;

    // pin sampled by three flops, change taken when the last two agree
    s_nxt.sel_sync = {s_r.sel_sync[1:0], i_interface_select_pin};
    if (s_r.sel_sync[2] == s_r.sel_sync[1]) begin
      s_nxt.proto = s_r.sel_sync[2] ? PROTO_I2C : PROTO_SPI;
    end

    s_nxt.temp = i_temp_code;
    // adc follows live except during a burst so both bytes stay one sample;
    // the high-byte read edge itself must hold too, else the low byte is newer
    if (!s_r.in_burst && !(i_req.rd && i_req.burst && a == ADDR_RESULT_HI)) begin
      s_nxt.adc_hold = i_adc_result;
    end

    // reads
    if (i_req.rd) begin
      s_nxt.rsp.rvalid = 1'b1;
      s_nxt.rsp.rdata  = 8'h00;
      unique case (a[5:4])
        PAGE_RO: begin
          unique case (a)
            ADDR_STATUS0:   s_nxt.rsp.rdata = s_r.status0;
            ADDR_STATUS1:   s_nxt.rsp.rdata = s_r.status1;
            ADDR_TEMP:      s_nxt.rsp.rdata = s_r.temp;
            ADDR_RESULT_HI: s_nxt.rsp.rdata = {6'h00, s_r.adc_hold[9:8]};
            ADDR_RESULT_LO: s_nxt.rsp.rdata = s_r.adc_hold[7:0];
            ADDR_REVISION:  s_nxt.rsp.rdata = REVISION_CODE;
            default:        s_nxt.rsp.rdata = 8'h00;
          endcase
        end
        PAGE_CFG: s_nxt.rsp.rdata = s_r.cfg[idx];
        PAGE_VAL: s_nxt.rsp.rdata = s_r.val[idx];
        default:  s_nxt.rsp.rdata = 8'h00;
      endcase
      // burst starting at the high byte freezes the pair until the burst ends
      if (a == ADDR_RESULT_HI && i_req.burst) begin
        s_nxt.in_burst = 1'b1;
      end
    end
    if (!i_req.burst) begin
      s_nxt.in_burst = 1'b0;
    end

    // status: clear on read, then new events set (set wins)
    if (i_req.rd && a == ADDR_STATUS0) begin
      s_nxt.status0 = 8'h00;
    end
    if (i_req.rd && a == ADDR_STATUS1) begin
      s_nxt.status1 = 8'h00;
    end
    s_nxt.status0 = s_nxt.status0 | i_status0_events;
    s_nxt.status1 = s_nxt.status1 | i_status1_events;
    if (ovt_now) begin
      s_nxt.status0[BIT_OVERTEMP] = 1'b1;
    end
    if (mismatch || mode_bad) begin
      s_nxt.status0[BIT_MEM_ERR] = 1'b1;
    end

    // writes
    if (i_req.wr) begin
      unique case (a[5:4])
        PAGE_CFG: begin
          if (cfg_mode || a == ADDR_MODE) begin
            s_nxt.cfg[idx] = i_req.wdata;
            s_nxt.val[idx] = ~i_req.wdata;
          end
        end
        PAGE_VAL: s_nxt.val[idx] = i_req.wdata;
        default: ;
      endcase
    end

    // transparent latch in operation mode, hold while configuring
    if (!cfg_mode) begin
      s_nxt.applied = s_nxt.cfg;
    end

    // configuration-mode timer
    if (!cfg_mode) begin
      s_nxt.cfg_time  = 32'h0000_0000;
      s_nxt.timed_out = 1'b0;
    end else if (s_r.cfg_time < TIMEOUT_CYCLES) begin
      s_nxt.cfg_time = s_r.cfg_time + 32'h0000_0001;
    end else if (!s_r.timed_out) begin
      s_nxt.timed_out = 1'b1;
      s_nxt.status0[BIT_TIMEOUT] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      s_r          <= '0;
      s_r.cfg[12]  <= MODE_REG_RESET;
      s_r.val      <= '1;
      s_r.val[12]  <= ~MODE_REG_RESET;
      s_r.applied[12] <= MODE_REG_RESET;
      s_r.status0  <= INIT_STATUS0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rsp         = s_r.rsp;
  assign o_proto       = s_r.proto;
  assign o_applied_cfg = s_r.applied;
  // overtemp, memory error or timeout switch the channel off
  assign o_laser_enable = !(s_r.status0[BIT_OVERTEMP] || s_r.status0[BIT_MEM_ERR]
                            || s_r.timed_out || ovt_now);
  assign o_error_out_n = ~(|(s_r.status0 & ~i_status_mask)
                           || |(s_r.status1 & ~i_status_mask) || ovt_now);

endmodule

// ### cfg_integrity_properties.sv
// checker: port relations of the register bank
module config_integrity_checker
  import cfg_integrity_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = CFG_TIMEOUT_CYC, // config-mode limit
  parameter logic [7:0]  OVT_LIMIT      = 8'hc8            // overtemp code
) (
  input wire logic         i_clock,                // clock
  input wire logic         i_sys_rst,              // reset
  input wire host_req_type i_req,                  // host access
  input wire host_rsp_type o_rsp,                  // read answer
  input wire logic         i_interface_select_pin, // protocol pin
  input wire proto_type    o_proto,                // chosen protocol
  input wire logic [7:0]   i_temp_code,            // temperature
  input wire logic [7:0]   i_status_mask,          // status mask
  input wire logic [127:0] o_applied_cfg,          // applied config
  input wire logic         o_laser_enable,         // laser enable
  input wire logic         o_error_out_n           // error out
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  logic [1:0]  mode_r;
  logic        sim_pend_r;
  logic        sim_r;
  int unsigned cnt_r;
  logic        quiet;
  assign quiet = mode_r == MODE_OPERATE && !(i_req.wr && i_req.addr == ADDR_MODE);
  // sim bit only lands while configuring, and acts once the latch reopens
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mode_r     <= MODE_OPERATE;
      sim_pend_r <= 1'b0;
      sim_r      <= 1'b0;
      cnt_r      <= 0;
    end else begin
      if (i_req.wr && i_req.addr == ADDR_MODE) mode_r <= i_req.wdata[1:0];
      if (i_req.wr && i_req.addr == ADDR_SIM_CTRL && mode_r == MODE_CONFIGURE)
        sim_pend_r <= i_req.wdata[BIT_SIM_OVT];
      if (mode_r != MODE_CONFIGURE) sim_r <= sim_pend_r;
      cnt_r <= (mode_r == MODE_CONFIGURE) ? cnt_r + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  rd_answer_a: assert property (i_req.rd |=> o_rsp.rvalid) else $error("no answer");
  rd_spur_a: assert property (!i_req.rd |=> !o_rsp.rvalid) else $error("stray answer");
  temp_read_a: assert property (
    i_req.rd && i_req.addr == ADDR_TEMP && $stable(i_temp_code)
    |=> o_rsp.rdata == $past(i_temp_code)) else $error("bad temperature");
  ovt_off_a: assert property (
    (i_temp_code > OVT_LIMIT)[*3] |-> !o_laser_enable) else $error("hot laser on");
  proto_sel_a: assert property ($stable(i_interface_select_pin)[*4] |->
    o_proto == (i_interface_select_pin ? PROTO_I2C : PROTO_SPI)) else $error("bad proto");
  cfg_hold_a: assert property (
    mode_r == MODE_CONFIGURE && $past(mode_r) == MODE_CONFIGURE
    |-> $stable(o_applied_cfg)) else $error("applied moved");
  cfg_apply_a: assert property (
    (mode_r == MODE_OPERATE)[*2] |-> o_applied_cfg[97:96] == MODE_OPERATE)
    else $error("not applied");
  op_reject_a: assert property (quiet[*3] |=> $stable(o_applied_cfg))
    else $error("write not refused");
  sim_ovt_a: assert property (sim_r[*3] |-> !o_laser_enable &&
    (i_status_mask[BIT_OVERTEMP] || !o_error_out_n)) else $error("sim ignored");
  cfg_timeout_a: assert property (cnt_r > TIMEOUT_CYCLES + 3 |-> !o_laser_enable)
    else $error("no timeout");
endmodule

// ### host_model.sv
// host model: one register access at a time toward the bank
module host_model
  import cfg_integrity_pkg::*;
(
  input  wire logic         i_clock, // bank clock
  output host_req_type      o_req,   // access toward the bank
  input  wire host_rsp_type i_rsp    // read answer
);
  initial o_req = '0;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b1, rd: 1'b0, burst: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    o_req.wr <= 1'b0;
  endtask
  // burst is a level: left up so the paired read sees frozen data
  task automatic rd(input logic [5:0] a, input logic b, output logic [7:0] d);
    @(posedge i_clock);
    o_req <= '{wr: 1'b0, rd: 1'b1, burst: b, addr: a, wdata: 8'h00};
    @(posedge i_clock);
    o_req.rd <= 1'b0;
    // answer stands from this edge on and is sampled at the next one
    @(posedge i_clock);
    d = i_rsp.rdata;
  endtask
endmodule

// ### tb_config_integrity_register_bank.sv
// testbench: self-checking run of the register bank
module tb_config_integrity_register_bank import cfg_integrity_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, sys_rst, sel, laser, err_n;
  host_req_type req;
  host_rsp_type rsp;
  proto_type proto;
  logic [7:0] temp, ev0, ev1, mask, d, v, w;
  logic [9:0] a;
  logic [127:0] applied;
  int err_total, n_checks;
  host_model i_host_model (.i_clock(clock), .o_req(req), .i_rsp(rsp));
  config_integrity_register_bank #(.TIMEOUT_CYCLES(20), .REVISION_CODE(8'h3c))
  i_config_integrity_register_bank (.i_clock(clock), .i_sys_rst(sys_rst), .i_req(req),
    .o_rsp(rsp), .i_interface_select_pin(sel), .o_proto(proto), .i_temp_code(temp),
    .i_adc_result(a), .i_status0_events(ev0), .i_status1_events(ev1),
    .i_status_mask(mask), .o_applied_cfg(applied), .o_laser_enable(laser),
    .o_error_out_n(err_n));
  initial clock = 1'b0;
  always #25 clock = ~clock;
  function automatic logic [7:0] bit8(input logic b);
    return {7'h00, b};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] ad, input logic [7:0] exp, input string s);
    i_host_model.rd(ad, 1'b0, d);
    chk(d, exp, s);
  endtask
  task automatic session(input logic [5:0] ad, input logic [7:0] val);
    i_host_model.wr(ADDR_MODE, 8'h06);
    i_host_model.wr(ad, val);
    i_host_model.wr(ADDR_MODE, 8'h05);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, sel, temp, a, ev0, ev1, mask} = {1'b1, 1'b0, 8'h40, 10'h000, 24'h0};
    void'($urandom(69));
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rchk(ADDR_STATUS0, INIT_STATUS0, "init");
    rchk(ADDR_STATUS0, 8'h00, "cleared");
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      temp <= (k == 0) ? 8'hc8 : 8'($urandom_range(199));
      repeat (2) @(posedge clock);
      rchk(ADDR_TEMP, temp, "temp");
    end
    rchk(ADDR_REVISION, 8'h3c, "revision");
    rchk(6'h25, 8'h00, "unmapped");
    w = 8'($urandom);
    @(posedge clock);
    a <= {w[1:0], ~w};
    i_host_model.rd(ADDR_RESULT_HI, 1'b1, d);
    a <= ~a;
    chk(d, {6'h00, w[1:0]}, "adc high");
    i_host_model.rd(ADDR_RESULT_LO, 1'b1, d);
    chk(d, ~w, "adc low");
    v = 8'($urandom) & 8'hf7;
    i_host_model.wr(ADDR_MODE, 8'h06);
    i_host_model.wr(6'h10, v);
    rchk(6'h10, v, "readback");
    rchk(6'h30, ~v, "inverse");
    chk(applied[7:0], 8'h00, "held");
    i_host_model.wr(ADDR_MODE, 8'h05);
    repeat (2) @(posedge clock);
    chk(applied[7:0], v, "applied");
    i_host_model.wr(6'h10, ~v);
    rchk(6'h10, v, "refused");
    i_host_model.wr(6'h30, v);
    rchk(6'h30, v, "plain store");
    chk(bit8(laser), 8'h00, "mismatch laser");
    i_host_model.wr(6'h30, ~v);
    rchk(ADDR_STATUS0, 8'h04, "mem error");
    rchk(ADDR_STATUS0, 8'h00, "mem clear");
    foreach (ev0[i]) if (i == 4 || i == 7) begin
      i_host_model.wr(ADDR_MODE, 8'(i));
      i_host_model.wr(ADDR_MODE, 8'h05);
      rchk(ADDR_STATUS0, 8'h04, "bad mode");
      rchk(ADDR_STATUS0, 8'h00, "mode clear");
    end
    @(posedge clock);
    temp <= 8'hc9;
    repeat (4) @(posedge clock);
    #1 chk(bit8(err_n), 8'h00, "ovt error");
    @(posedge clock);
    temp <= 8'h30;
    rchk(ADDR_STATUS0, 8'h08, "ovt");
    rchk(ADDR_STATUS0, 8'h00, "ovt clear");
    for (int s = 1; s >= 0; s--) begin
      session(ADDR_SIM_CTRL, 8'(s << BIT_SIM_OVT));
      // latch reopens one edge after the mode write, flag sets one edge later
      repeat (2) @(posedge clock);
      rchk(ADDR_STATUS0, 8'h08, "sim");
      rchk(ADDR_STATUS0, 8'(s << 3), "sim hold");
    end
    i_host_model.wr(ADDR_MODE, 8'h06);
    repeat (30) @(posedge clock);
    chk(bit8(laser), 8'h00, "timeout");
    i_host_model.wr(ADDR_MODE, 8'h05);
    rchk(ADDR_STATUS0, 8'h80, "timeout flag");
    w = 8'($urandom_range(31)) | 8'h01;
    v = 8'($urandom) & 8'h70;
    @(posedge clock);
    {ev0, ev1} <= {v, w};
    @(posedge clock);
    {ev0, ev1, mask} <= {16'h0, v | w};
    @(posedge clock);
    #1 chk(bit8(err_n), 8'h01, "masked");
    @(posedge clock);
    mask <= 8'h00;
    @(posedge clock);
    #1 chk(bit8(err_n), 8'h00, "unmasked");
    rchk(ADDR_STATUS1, w, "status1");
    rchk(ADDR_STATUS0, v, "status0");
    for (int p = 1; p >= 0; p--) begin
      @(posedge clock);
      sel <= p[0];
      repeat (4) @(posedge clock);
      #1 chk({6'h00, proto}, {6'h00, p[0] ? PROTO_I2C : PROTO_SPI}, "proto");
    end
    report_and_stop();
  end
endmodule
bind config_integrity_register_bank config_integrity_checker #(
  .TIMEOUT_CYCLES(TIMEOUT_CYCLES), .OVT_LIMIT(OVT_LIMIT)) i_checker (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_req(i_req), .o_rsp(o_rsp), .o_proto(o_proto),
  .i_interface_select_pin(i_interface_select_pin), .i_temp_code(i_temp_code),
  .i_status_mask(i_status_mask), .o_applied_cfg(o_applied_cfg),
  .o_laser_enable(o_laser_enable), .o_error_out_n(o_error_out_n));
